// >>> logic/cli_defines.vh
`ifndef CLI_DEFINES_VH
`define CLI_DEFINES_VH

// register byte addresses
`define CLI_ADDR_CTRL 8'h00
`define CLI_ADDR_KEY 8'h04
`define CLI_ADDR_IDLE 8'h08
`define CLI_ADDR_PICKUP 8'h0c
`define CLI_ADDR_DURATION 8'h10
`define CLI_ADDR_HARM 8'h14
`define CLI_ADDR_STATUS 8'h18
`define CLI_ADDR_PEAK 8'h1c
`define CLI_ADDR_IDLE_PRI 8'h20
`define CLI_ADDR_PICK_PRI 8'h24
`define CLI_ADDR_CT_SCALE 8'h28
`define CLI_ADDR_IRQ_STAT 8'h2c
`define CLI_ADDR_IRQ_MASK 8'h30

// reset values
`define CLI_RST_CTRL 1'h1
`define CLI_RST_IDLE 16'h0019
`define CLI_RST_PICKUP 16'h0200
`define CLI_RST_DURATION 16'h03e8
`define CLI_RST_HARM 8'h14
`define CLI_RST_CT_SCALE 16'h0064
// unlock key: value is arbitrary
`define CLI_UNLOCK_KEY 32'h0000c1d5

// status fields
`define CLI_ST_COLD_LSB 0
`define CLI_ST_INRUSH_LSB 2
`define CLI_ST_BLOCK 4
`define CLI_ST_ARMED 5
`define CLI_ST_HARM_DONE 6
`define CLI_ST_UNLOCKED 7
`define CLI_STAT_IDLE 2'h0
`define CLI_STAT_START 2'h1
`define CLI_STAT_TRIP 2'h2

// event bits
`define CLI_EV_COLD_START 0
`define CLI_EV_COLD_TIMEOUT 1
`define CLI_EV_INRUSH_START 2
`define CLI_EV_INRUSH_TIMEOUT 3
`define CLI_EV_WRITE_REFUSED 4
`define CLI_EV_W 5

// timing
`define CLI_CLK_PERIOD_PS 25000
`define CLI_TICK_US 1000
`define CLI_TICK_CYCLES (`CLI_TICK_US * 1000000 / `CLI_CLK_PERIOD_PS)
`define CLI_START_WINDOW_MS 80
`define CLI_SAMPLES_PER_CYCLE 32

`endif

// >>> logic/cli_tick_div.v
`timescale 1ns/1ps
`default_nettype none
module cli_tick_div #(
    parameter CYCLES = 40000,
    parameter W = 17
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // control
    input wire restart,
    // output
    output reg tick
);
    reg [W-1:0] cnt_reg;

    always @(posedge aclk)
    begin
        if (!aresetn || restart)
        begin
            cnt_reg <= {W{1'b0}};
            tick <= 1'b0;
        end
        else if (cnt_reg == CYCLES[W-1:0] - 1'b1)
        begin
            cnt_reg <= {W{1'b0}};
            tick <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> logic/cli_harm_eval.v
`timescale 1ns/1ps
`default_nettype none
module cli_harm_eval #(
    parameter NPH = 3,
    parameter RW = 8,
    parameter SPC = 32
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // control
    input wire start,
    input wire sample_strobe,
    input wire [NPH*RW-1:0] ratio_bus,
    input wire [RW-1:0] threshold,
    // result
    output reg done_reg,
    output reg present_reg
);
    reg [6:0] cnt_reg;
    wire [NPH-1:0] above;

    genvar i;
    generate
        for (i = 0; i < NPH; i = i + 1)
        begin : g_phase
            assign above[i] = ratio_bus[i*RW +: RW] > threshold;
        end
    endgenerate

    // decision latched once, after a whole cycle of transform input
    always @(posedge aclk)
    begin
        if (!aresetn || start)
        begin
            cnt_reg <= 7'h00;
            done_reg <= 1'b0;
            present_reg <= 1'b0;
        end
        else if (sample_strobe && !done_reg)
        begin
            cnt_reg <= cnt_reg + 7'h01;
            if (cnt_reg == SPC[6:0] - 7'h01)
            begin
                done_reg <= 1'b1;
                present_reg <= |above;
            end
        end
    end
endmodule
`default_nettype wire

// >>> logic/cli_detector.v
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cli_defines.vh"
module cli_detector #(
    parameter TICK_CYCLES = `CLI_TICK_CYCLES,
    parameter CW = 16,
    parameter RW = 8
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // measurement front end
    input wire meas_valid,
    input wire [CW-1:0] phase_current_a,
    input wire [CW-1:0] phase_current_b,
    input wire [CW-1:0] phase_current_c,
    input wire sample_strobe,
    input wire [RW-1:0] second_harmonic_ratio_a,
    input wire [RW-1:0] second_harmonic_ratio_b,
    input wire [RW-1:0] second_harmonic_ratio_c,
    // to output and blocking matrices
    output reg cold_load_detect,
    output reg inrush_detect,
    output reg inrush_block,
    output wire [1:0] cold_load_status,
    output wire [1:0] inrush_status,
    // interrupt
    output reg irq
);
    // ****
    // state encoding
    // ****
    localparam ST_WAIT_IDLE = 4'h1;
    localparam ST_ARMED = 4'h2;
    localparam ST_RISE = 4'h4;
    localparam ST_ACTIVE = 4'h8;

    // ****
    // registers
    // ****
    reg enable_reg;
    reg unlock_reg;
    reg [15:0] idle_limit_reg;
    reg [15:0] pickup_level_reg;
    reg [15:0] activation_duration_limit_reg;
    reg [7:0] harmonic_ratio_threshold_reg;
    reg [15:0] ct_scale_reg;
    reg [`CLI_EV_W-1:0] irq_stat_reg;
    reg [`CLI_EV_W-1:0] irq_mask_reg;
    reg [CW-1:0] cur_a_reg;
    reg [CW-1:0] cur_b_reg;
    reg [CW-1:0] cur_c_reg;
    reg [CW-1:0] peak_phase_current_reg;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [6:0] window_cnt_reg;
    reg [15:0] dur_cnt_reg;
    reg cold_trip_reg;
    reg inrush_trip_reg;
    reg inrush_seen_reg;
    reg aw_held_reg;
    reg w_held_reg;
    reg [7:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg [31:0] rd_mux;
    reg rd_hit;
    reg [`CLI_EV_W-1:0] ev;

    wire tick;
    wire harm_done;
    wire harm_present;
    wire all_idle;
    wire any_pick;
    wire thr_zero;
    wire inrush_on;
    wire block_on;
    wire do_write;
    wire key_ok;
    wire prot_addr;
    wire wr_refused;
    wire [31:0] wmask;
    wire [31:0] idle_pri;
    wire [31:0] pick_pri;

    // ****
    // peak supervision
    // ****
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cur_a_reg <= {CW{1'b0}};
            cur_b_reg <= {CW{1'b0}};
            cur_c_reg <= {CW{1'b0}};
            peak_phase_current_reg <= {CW{1'b0}};
        end
        else
        begin
            if (meas_valid)
            begin
                cur_a_reg <= phase_current_a;
                cur_b_reg <= phase_current_b;
                cur_c_reg <= phase_current_c;
            end
            if (cur_a_reg >= cur_b_reg && cur_a_reg >= cur_c_reg)
                peak_phase_current_reg <= cur_a_reg;
            else if (cur_b_reg >= cur_c_reg)
                peak_phase_current_reg <= cur_b_reg;
            else
                peak_phase_current_reg <= cur_c_reg;
        end
    end

    // limits compare against the peak, so all phases are covered at once
    assign all_idle = peak_phase_current_reg < idle_limit_reg;
    assign any_pick = peak_phase_current_reg > pickup_level_reg;

    // ****
    // timing helpers
    // ****
    // divider restarts on each timed phase so windows are not short by a tick
    cli_tick_div #(
        .CYCLES(TICK_CYCLES),
        .W(17)
    ) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(state_next != state_reg),
        .tick(tick)
    );

    cli_harm_eval #(
        .NPH(3),
        .RW(RW),
        .SPC(`CLI_SAMPLES_PER_CYCLE)
    ) u_harm (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(state_reg != ST_ACTIVE && state_next == ST_ACTIVE),
        .sample_strobe(sample_strobe),
        .ratio_bus({second_harmonic_ratio_c, second_harmonic_ratio_b,
            second_harmonic_ratio_a}),
        .threshold(harmonic_ratio_threshold_reg),
        .done_reg(harm_done),
        .present_reg(harm_present)
    );

    // ****
    // detection state machine
    // ****
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_WAIT_IDLE:
                if (enable_reg && all_idle)
                    state_next = ST_ARMED;
            ST_ARMED:
                if (!enable_reg)
                    state_next = ST_WAIT_IDLE;
                else if (any_pick)
                    state_next = ST_ACTIVE;
                else if (!all_idle)
                    state_next = ST_RISE;
            ST_RISE:
                if (!enable_reg)
                    state_next = ST_WAIT_IDLE;
                else if (any_pick)
                    state_next = ST_ACTIVE;
                else if (all_idle)
                    state_next = ST_ARMED;
                else if (window_cnt_reg >= `CLI_START_WINDOW_MS)
                    state_next = ST_WAIT_IDLE;
            ST_ACTIVE:
                if (!enable_reg || !any_pick)
                    state_next = ST_WAIT_IDLE;
                else if (dur_cnt_reg >= activation_duration_limit_reg)
                    state_next = ST_WAIT_IDLE;
            default:
                state_next = ST_WAIT_IDLE;
        endcase
    end

    assign thr_zero = harmonic_ratio_threshold_reg == 8'h00;
    assign inrush_on = (state_reg == ST_ACTIVE) &&
        (thr_zero || (harm_done && harm_present));
    assign block_on = (state_reg == ST_ACTIVE) &&
        (thr_zero || !harm_done || harm_present);

    always @*
    begin
        ev = {`CLI_EV_W{1'b0}};
        ev[`CLI_EV_COLD_START] = state_reg != ST_ACTIVE && state_next == ST_ACTIVE;
        ev[`CLI_EV_COLD_TIMEOUT] = state_reg == ST_ACTIVE && any_pick && enable_reg &&
            dur_cnt_reg >= activation_duration_limit_reg;
        ev[`CLI_EV_INRUSH_START] = inrush_on && !inrush_seen_reg;
        ev[`CLI_EV_INRUSH_TIMEOUT] = ev[`CLI_EV_COLD_TIMEOUT] && inrush_on;
        ev[`CLI_EV_WRITE_REFUSED] = wr_refused;
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= ST_WAIT_IDLE;
            window_cnt_reg <= 7'h00;
            dur_cnt_reg <= 16'h0000;
            cold_trip_reg <= 1'b0;
            inrush_trip_reg <= 1'b0;
            inrush_seen_reg <= 1'b0;
            cold_load_detect <= 1'b0;
            inrush_detect <= 1'b0;
            inrush_block <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_next != state_reg)
            begin
                window_cnt_reg <= 7'h00;
                dur_cnt_reg <= 16'h0000;
            end
            else if (tick)
            begin
                if (window_cnt_reg != 7'h7f)
                    window_cnt_reg <= window_cnt_reg + 7'h01;
                if (dur_cnt_reg != 16'hffff)
                    dur_cnt_reg <= dur_cnt_reg + 16'h0001;
            end
            if (ev[`CLI_EV_COLD_TIMEOUT])
                cold_trip_reg <= 1'b1;
            if (ev[`CLI_EV_INRUSH_TIMEOUT])
                inrush_trip_reg <= 1'b1;
            if (state_next == ST_ARMED)
            begin
                cold_trip_reg <= 1'b0;
                inrush_trip_reg <= 1'b0;
            end
            inrush_seen_reg <= inrush_on;
            cold_load_detect <= state_reg == ST_ACTIVE;
            inrush_detect <= inrush_on;
            inrush_block <= block_on;
        end
    end

    assign cold_load_status = cold_load_detect ? `CLI_STAT_START :
        cold_trip_reg ? `CLI_STAT_TRIP : `CLI_STAT_IDLE;
    assign inrush_status = inrush_detect ? `CLI_STAT_START :
        inrush_trip_reg ? `CLI_STAT_TRIP : `CLI_STAT_IDLE;

    // ****
    // register bus
    // ****
    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready = !w_held_reg;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
        {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    assign key_ok = w_data_reg == `CLI_UNLOCK_KEY && w_strb_reg == 4'hf;
    assign prot_addr = aw_addr_reg == `CLI_ADDR_IDLE || aw_addr_reg == `CLI_ADDR_PICKUP ||
        aw_addr_reg == `CLI_ADDR_DURATION || aw_addr_reg == `CLI_ADDR_HARM;
    // the idle, pickup, duration and harmonic settings stay put unless a key write opened them since the last such write
    assign wr_refused = do_write && prot_addr && !unlock_reg;
    assign idle_pri = idle_limit_reg * ct_scale_reg;
    assign pick_pri = pickup_level_reg * ct_scale_reg;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            enable_reg <= `CLI_RST_CTRL;
            unlock_reg <= 1'b0;
            idle_limit_reg <= `CLI_RST_IDLE;
            pickup_level_reg <= `CLI_RST_PICKUP;
            activation_duration_limit_reg <= `CLI_RST_DURATION;
            harmonic_ratio_threshold_reg <= `CLI_RST_HARM;
            ct_scale_reg <= `CLI_RST_CT_SCALE;
            irq_stat_reg <= {`CLI_EV_W{1'b0}};
            irq_mask_reg <= {`CLI_EV_W{1'b0}};
            irq <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && !aw_held_reg)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && !w_held_reg)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            // a set arriving with its clear wins
            irq_stat_reg <= irq_stat_reg | ev;
            if (do_write)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_refused ? 2'h2 : 2'h0;
                if (prot_addr && unlock_reg)
                    unlock_reg <= 1'b0;
                case (aw_addr_reg)
                    `CLI_ADDR_CTRL:
                        if (w_strb_reg[0])
                            enable_reg <= w_data_reg[0];
                    `CLI_ADDR_KEY:
                        unlock_reg <= key_ok;
                    `CLI_ADDR_IDLE:
                        if (unlock_reg)
                            idle_limit_reg <= (idle_limit_reg & ~wmask[15:0]) |
                                (w_data_reg[15:0] & wmask[15:0]);
                    `CLI_ADDR_PICKUP:
                        if (unlock_reg)
                            pickup_level_reg <= (pickup_level_reg & ~wmask[15:0]) |
                                (w_data_reg[15:0] & wmask[15:0]);
                    `CLI_ADDR_DURATION:
                        if (unlock_reg)
                            activation_duration_limit_reg <=
                                (activation_duration_limit_reg & ~wmask[15:0]) |
                                (w_data_reg[15:0] & wmask[15:0]);
                    `CLI_ADDR_HARM:
                        if (unlock_reg && w_strb_reg[0])
                            harmonic_ratio_threshold_reg <= w_data_reg[7:0];
                    `CLI_ADDR_CT_SCALE:
                        ct_scale_reg <= (ct_scale_reg & ~wmask[15:0]) |
                            (w_data_reg[15:0] & wmask[15:0]);
                    `CLI_ADDR_IRQ_STAT:
                        if (w_strb_reg[0])
                            irq_stat_reg <= (irq_stat_reg & ~w_data_reg[`CLI_EV_W-1:0]) | ev;
                    `CLI_ADDR_IRQ_MASK:
                        if (w_strb_reg[0])
                            irq_mask_reg <= w_data_reg[`CLI_EV_W-1:0];
                    `CLI_ADDR_STATUS, `CLI_ADDR_PEAK, `CLI_ADDR_IDLE_PRI, `CLI_ADDR_PICK_PRI:
                        s_axi_bresp <= 2'h0;
                    default:
                        s_axi_bresp <= 2'h3;
                endcase
            end
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    always @*
    begin
        rd_hit = 1'b1;
        rd_mux = 32'h00000000;
        case (s_axi_araddr[7:2])
            `CLI_ADDR_CTRL >> 2: rd_mux[0] = enable_reg;
            `CLI_ADDR_KEY >> 2: rd_mux = 32'h00000000;
            `CLI_ADDR_IDLE >> 2: rd_mux[15:0] = idle_limit_reg;
            `CLI_ADDR_PICKUP >> 2: rd_mux[15:0] = pickup_level_reg;
            `CLI_ADDR_DURATION >> 2: rd_mux[15:0] = activation_duration_limit_reg;
            `CLI_ADDR_HARM >> 2: rd_mux[7:0] = harmonic_ratio_threshold_reg;
            `CLI_ADDR_STATUS >> 2:
            begin
                rd_mux[`CLI_ST_COLD_LSB +: 2] = cold_load_status;
                rd_mux[`CLI_ST_INRUSH_LSB +: 2] = inrush_status;
                rd_mux[`CLI_ST_BLOCK] = inrush_block;
                rd_mux[`CLI_ST_ARMED] = state_reg == ST_ARMED;
                rd_mux[`CLI_ST_HARM_DONE] = harm_done;
                rd_mux[`CLI_ST_UNLOCKED] = unlock_reg;
            end
            `CLI_ADDR_PEAK >> 2: rd_mux[CW-1:0] = peak_phase_current_reg;
            `CLI_ADDR_IDLE_PRI >> 2: rd_mux = idle_pri;
            `CLI_ADDR_PICK_PRI >> 2: rd_mux = pick_pri;
            `CLI_ADDR_CT_SCALE >> 2: rd_mux[15:0] = ct_scale_reg;
            `CLI_ADDR_IRQ_STAT >> 2: rd_mux[`CLI_EV_W-1:0] = irq_stat_reg;
            `CLI_ADDR_IRQ_MASK >> 2: rd_mux[`CLI_EV_W-1:0] = irq_mask_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? 2'h0 : 2'h3;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule
`default_nettype wire

// >>> sim/cli_fe_model.sv
`timescale 1ns/1ps
`default_nettype none
module cli_fe_model (
    // clock
    input wire logic aclk,
    // levels the bench asks for
    input wire logic [15:0] lvl_a,
    input wire logic [15:0] lvl_b,
    input wire logic [15:0] lvl_c,
    input wire logic [7:0] rat,
    // front end outputs
    output logic meas_valid = 1'b0,
    output logic sample_strobe = 1'b0,
    output logic [15:0] phase_current_a = 16'h0000,
    output logic [15:0] phase_current_b = 16'h0000,
    output logic [15:0] phase_current_c = 16'h0000,
    output logic [7:0] second_harmonic_ratio_a,
    output logic [7:0] second_harmonic_ratio_b,
    output logic [7:0] second_harmonic_ratio_c
);
    // ****
    // one sample every four clocks, 32 to a power cycle
    // ****
    logic [1:0] div = 2'h0;
    wire hit = (div == 2'h3);
    assign second_harmonic_ratio_a = rat;
    assign second_harmonic_ratio_b = 8'h00;
    assign second_harmonic_ratio_c = 8'h00;
    always @(posedge aclk)
    begin
        div <= div + 2'h1;
        meas_valid <= hit;
        sample_strobe <= hit;
        // inverted between samples so a late latch shows up
        phase_current_a <= hit ? lvl_a : ~lvl_a;
        phase_current_b <= hit ? lvl_b : ~lvl_b;
        phase_current_c <= hit ? lvl_c : ~lvl_c;
    end
endmodule
`default_nettype wire

// >>> sim/cli_detector_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cli_detector_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus answers
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // detection outputs
    input wire logic cold_load_detect,
    input wire logic inrush_detect,
    input wire logic inrush_block,
    input wire logic [1:0] cold_load_status,
    input wire logic [1:0] inrush_status
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer not held");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not held");
    inrush_sub_a: assert property (inrush_detect |-> cold_load_detect)
        else $error("inrush without start conditions");
    block_sub_a: assert property (inrush_block |-> cold_load_detect)
        else $error("block without start conditions");
    detect_block_a: assert property (inrush_detect |-> inrush_block)
        else $error("inrush seen but not blocking");
    cold_start_a: assert property ($rose(cold_load_detect) |->
        ##[0:1] cold_load_status == 2'h1)
        else $error("cold status not start");
    inrush_start_a: assert property ($rose(inrush_detect) |->
        ##[0:1] inrush_status == 2'h1)
        else $error("inrush status not start");
    cold_end_a: assert property ($fell(cold_load_detect) |-> cold_load_status != 2'h1)
        else $error("status still start after release");
    status_code_a: assert property (cold_load_status != 2'h3 && inrush_status != 2'h3)
        else $error("status code out of range");
    cover property ($rose(cold_load_detect));
    cover property ($rose(inrush_detect));
    cover property (cold_load_status == 2'h2);
endmodule
bind cli_detector cli_detector_chk cli_detector_chk_inst (.*);
`default_nettype wire

// >>> sim/cli_detector_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cli_detector_tb;
    // ****
    // bench
    // ****
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rat = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [15:0] lvl_a = 16'h0, lvl_b = 16'h0, lvl_c = 16'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire meas_valid, sample_strobe, cold_load_detect, inrush_detect, inrush_block, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp, cold_load_status, inrush_status;
    wire [31:0] s_axi_rdata;
    wire [15:0] phase_current_a, phase_current_b, phase_current_c;
    wire [7:0] second_harmonic_ratio_a, second_harmonic_ratio_b, second_harmonic_ratio_c;
    wire [7:0] obs = {inrush_status, cold_load_status, irq,
        inrush_detect, inrush_block, cold_load_detect};
    int fails = 0, check_count = 0;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    logic [33:0] e;
    logic [31:0] lf = 32'h000147f4;
    always #12.5 aclk = ~aclk;
    // short ms tick keeps the 80 ms window at 640 clocks
    cli_detector #(.TICK_CYCLES(8)) cli_detector_inst (.*);
    cli_fe_model cli_fe_model_inst (.*);
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tmo;
        fails++;
        $display("ERROR %0t: wait ran out", $time);
        wrap_up();
    endtask
    task automatic ob(input logic [7:0] x);
        chk({24'h0, obs}, {24'h0, x});
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task automatic wt(input int i, input logic v, input int lim);
        for (int k = 0; k < lim; k++)
        begin
            @(negedge aclk);
            if (obs[i] === v)
                return;
        end
        tmo();
    endtask
    task automatic lv(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        @(posedge aclk);
        lvl_a <= a;
        lvl_b <= b;
        lvl_c <= c;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tw, tb = 1'b0;
        bq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int k = 0; k < 100 && !tb; k++)
        begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid && s_axi_bready;
            @(posedge aclk);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        if (!tb)
            tmo();
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] x);
        logic ta, t = 1'b0;
        rq.push_back(x);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int k = 0; k < 100 && !t; k++)
        begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            t = s_axi_rvalid && s_axi_rready;
            @(posedge aclk);
            if (ta)
                s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        if (!t)
            tmo();
    endtask
    // ****
    // answer monitor
    // ****
    always @(negedge aclk)
    begin
        if (s_axi_bvalid && s_axi_bready)
            chk({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
        if (s_axi_rvalid && s_axi_rready)
        begin
            e = rq.pop_front();
            chk({30'h0, s_axi_rresp}, {30'h0, e[33:32]});
            if (e[33:32] == 2'h0)
                chk(s_axi_rdata, e[31:0]);
        end
    end
    // ****
    // scenarios
    // ****
    initial
    begin
        cyc(2);
        aresetn <= 1'b1;
        rd(8'h08, {2'h0, 32'h19});
        rd(8'hfc, {2'h3, 32'h0});
        wr(8'h10, 32'h1e, 2'h2);
        wr(8'h04, 32'hc1d5, 2'h0);
        wr(8'h10, 32'h1e, 2'h0);
        rd(8'h10, {2'h0, 32'h1e});
        rd(8'h20, {2'h0, 32'h9c4});
        wr(8'h30, 32'h1f, 2'h0);
        $display("scenario 1 done");
        lf = nx(lf);
        lv({12'h0, lf[3:0]}, {12'h0, lf[7:4]}, 16'h0002);
        cyc(30);
        lv(16'h0400, 16'h0300, {8'h0, lf[15:8]});
        wt(0, 1'b1, 40);
        cyc(2);
        ob(8'h1b);
        rd(8'h1c, {2'h0, 32'h400});
        cyc(90);
        ob(8'h1b);
        wt(1, 1'b0, 100);
        ob(8'h19);
        wt(0, 1'b0, 300);
        cyc(2);
        chk({30'h0, cold_load_status}, 32'h2);
        wr(8'h30, 32'h0, 2'h0);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        wr(8'h30, 32'h1f, 2'h0);
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        wr(8'h2c, 32'h1f, 2'h0);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        cyc(100);
        chk({31'h0, cold_load_detect}, 32'h0);
        $display("scenario 2 done");
        lv(16'h10, 16'h10, 16'h10);
        cyc(30);
        lv(16'h100, 16'h100, 16'h100);
        cyc(700);
        lv(16'h400, 16'h400, 16'h400);
        cyc(40);
        chk({31'h0, cold_load_detect}, 32'h0);
        $display("scenario 3 done");
        lv(16'h10, 16'h10, 16'h10);
        cyc(30);
        rat <= 8'h40;
        lv(16'h0400, 16'h0000, 16'h0000);
        wt(0, 1'b1, 40);
        wt(2, 1'b1, 200);
        cyc(2);
        ob(8'h5f);
        lv(16'h100, 16'h100, 16'h100);
        wt(0, 1'b0, 20);
        cyc(2);
        chk({30'h0, cold_load_status}, 32'h0);
        $display("scenario 4 done");
        wr(8'h04, 32'hc1d5, 2'h0);
        wr(8'h14, 32'h0, 2'h0);
        rat <= 8'h00;
        lv(16'h10, 16'h10, 16'h10);
        cyc(30);
        lv(16'h400, 16'h400, 16'h400);
        wt(0, 1'b1, 40);
        cyc(2);
        ob(8'h5f);
        cyc(150);
        ob(8'h5f);
        wt(0, 1'b0, 200);
        cyc(2);
        ob(8'ha8);
        $display("scenario 5 done");
        wrap_up();
    end
endmodule
`default_nettype wire
